// ===== rtl/ial_gpr_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ial_gpr_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [AW-1:0] rd_addr_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [WIDTH-1:0] rd_data_a_ff,
  output logic [WIDTH-1:0] rd_data_b_ff,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // contents are not reset; software loads them through add-immediate-shifted then or-immediate
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read-before-write: a same-edge write shows on the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_a_ff <= '0;
      rd_data_b_ff <= '0;
    end else begin
      rd_data_a_ff <= mem[rd_addr_a];
      rd_data_b_ff <= mem[rd_addr_b];
    end
  end
endmodule : ial_gpr_mem
`default_nettype wire

// ===== rtl/ial_pkg.sv
package ial_pkg;
  localparam int XLEN = 32;
  localparam int REG_AW = 5;
  localparam int REG_N = 32;
  localparam int IMM_W = 16;
  localparam int CRF_W = 3;
  localparam int FIELD_W = 4;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_XER = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CR = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CNT = 12'h00c;
  localparam int XER_SO = 31;
  localparam int XER_OV = 30;
  localparam int XER_CA = 29;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NOP = 1;
  localparam logic [XLEN-1:0] XER_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] CR_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [XLEN-1:0] MIN_INT = 32'h8000_0000;
  localparam logic [CRF_W-1:0] CRF_ZERO = 3'h0;

  typedef enum logic [5:0] {
    OP_ADDI = 6'h00, OP_ADDIS = 6'h01, OP_ADD = 6'h02, OP_SUBF = 6'h03,
    OP_ADDIC = 6'h04, OP_ADDIC_REC = 6'h05, OP_SUBFIC = 6'h06,
    OP_ADDC = 6'h07, OP_SUBFC = 6'h08, OP_ADDE = 6'h09, OP_SUBFE = 6'h0a,
    OP_ADDME = 6'h0b, OP_SUBFME = 6'h0c, OP_ADDZE = 6'h0d,
    OP_SUBFZE = 6'h0e, OP_NEG = 6'h0f, OP_MULLI = 6'h10, OP_MULLW = 6'h11,
    OP_MULHW = 6'h12, OP_MULHWU = 6'h13, OP_DIVW = 6'h14,
    OP_DIVWU = 6'h15, OP_CMPI = 6'h16, OP_CMP = 6'h17, OP_CMPLI = 6'h18,
    OP_CMPL = 6'h19, OP_ANDI = 6'h1a, OP_ANDIS = 6'h1b, OP_ORI = 6'h1c,
    OP_ORIS = 6'h1d, OP_XORI = 6'h1e, OP_XORIS = 6'h1f, OP_AND = 6'h20,
    OP_OR = 6'h21, OP_XOR = 6'h22, OP_NAND = 6'h23, OP_NOR = 6'h24,
    OP_EQV = 6'h25, OP_ANDC = 6'h26, OP_ORC = 6'h27, OP_EXTSB = 6'h28,
    OP_EXTSH = 6'h29, OP_CNTLZW = 6'h2a
  } ial_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10
  } ial_state_t;

  function automatic logic is_compare(input ial_op_t op);
    return op inside {OP_CMPI, OP_CMP, OP_CMPLI, OP_CMPL};
  endfunction : is_compare

  function automatic logic is_logic(input ial_op_t op);
    return op inside {[OP_ANDI:OP_CNTLZW]};
  endfunction : is_logic

  function automatic logic sets_ca(input ial_op_t op);
    return op inside {[OP_ADDIC:OP_SUBFZE]};
  endfunction : sets_ca

  function automatic logic has_oe(input ial_op_t op);
    return op inside {OP_ADD, OP_SUBF, [OP_ADDC:OP_NEG], OP_MULLW,
                      OP_DIVW, OP_DIVWU};
  endfunction : has_oe

  function automatic logic always_rec(input ial_op_t op);
    return op inside {OP_ADDIC_REC, OP_ANDI, OP_ANDIS};
  endfunction : always_rec

  function automatic logic has_rc(input ial_op_t op);
    return !(op inside {OP_ADDI, OP_ADDIS, OP_ADDIC, OP_SUBFIC, OP_MULLI,
                        [OP_CMPI:OP_XORIS]});
  endfunction : has_rc

  // lsb of a condition field; field zero sits in the top nibble
  function automatic int field_lsb(input logic [CRF_W-1:0] crf);
    return XLEN - FIELD_W * (int'(crf) + 1);
  endfunction : field_lsb

  function automatic logic [FIELD_W-1:0] cr_char(input logic [XLEN-1:0] v,
                                                 input logic so);
    return {v[XLEN-1], !v[XLEN-1] && (v != '0), v == '0, so};
  endfunction : cr_char
endpackage : ial_pkg

// ===== rtl/ial_top.sv
`timescale 1ns/100ps
`default_nettype none
module ial_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic op_valid,
  input wire ial_pkg::ial_op_t op_code,
  input wire logic [ial_pkg::REG_AW-1:0] op_dst,
  input wire logic [ial_pkg::REG_AW-1:0] op_src_a,
  input wire logic [ial_pkg::REG_AW-1:0] op_src_b,
  input wire logic [ial_pkg::IMM_W-1:0] op_imm,
  input wire logic op_oe,
  input wire logic op_rc,
  input wire logic [ial_pkg::CRF_W-1:0] op_crf,
  input wire logic op_trace_pend,
  output logic op_ready_ff,
  output logic done_ff,
  output logic nop_drop_ff,
  output logic [ial_pkg::XLEN-1:0] result_ff,
  output logic [ial_pkg::XLEN-1:0] xer_ff,
  output logic [ial_pkg::XLEN-1:0] cr_ff,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ial_pkg::ADDR_W-1:0] paddr,
  input wire logic [ial_pkg::XLEN-1:0] pwdata,
  output logic [ial_pkg::XLEN-1:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff
);
  import ial_pkg::*;

  ial_state_t state_ff, nxt_state;
  ial_op_t op_q;
  logic [REG_AW-1:0] dst_q, src_a_q, src_b_q;
  logic [IMM_W-1:0] imm_q;
  logic [CRF_W-1:0] crf_q;
  logic oe_q, rc_q, take, is_nop, exec_go, gpr_we, rec, ov_en;
  logic [XLEN-1:0] rd_a, rd_b, ra_or0, signed_immediate_x, unsigned_immediate_x, imm_hi;
  logic [XLEN-1:0] add_x, add_y, mul_b, cmp_b, quot_s, quot_u, res;
  logic [XLEN:0] sum;
  logic add_cin, sum_ov, mul_ov, div_zero, div_ovs, ov, so_new;
  logic cmp_lt, cmp_eq;
  logic [2*XLEN-1:0] prod_s, prod_u;
  logic [FIELD_W-1:0] cmp_nib;
  logic [XLEN-1:0] cnt_ff, rd_word;
  logic rd_hit, apb_done, sw_xer_wr, sw_cr_wr;

  assign take = (state_ff == ST_IDLE) && op_valid && op_ready_ff;
  assign is_nop = (op_code == OP_ORI) && (op_dst == '0) &&
                  (op_src_a == '0) && (op_imm == '0) && !op_trace_pend;
  assign exec_go = (state_ff == ST_EXEC);

  // ops are latched once so the register file addresses stay put
  always_ff @(posedge clock) begin
    if (rst) begin
      op_q <= OP_ADDI;
      dst_q <= '0;
      src_a_q <= '0;
      src_b_q <= '0;
      imm_q <= '0;
      crf_q <= CRF_ZERO;
      oe_q <= 1'b0;
      rc_q <= 1'b0;
    end else if (take && !is_nop) begin
      op_q <= op_code;
      dst_q <= op_dst;
      src_a_q <= op_src_a;
      src_b_q <= op_src_b;
      imm_q <= op_imm;
      crf_q <= op_crf;
      oe_q <= op_oe;
      rc_q <= op_rc;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take && !is_nop) begin
          nxt_state = ST_READ;
        end
      end
      ST_READ: nxt_state = ST_EXEC;
      ST_EXEC: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // every op except a dropped no-op holds off the next one until its flags are written
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      op_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ready_ff <= (nxt_state == ST_IDLE);
    end
  end

  ial_gpr_mem #(.WIDTH(XLEN), .DEPTH(REG_N), .AW(REG_AW)) u_gpr (
    .clock(clock),
    .rst(rst),
    .rd_addr_a(src_a_q),
    .rd_addr_b(src_b_q),
    .rd_data_a_ff(rd_a),
    .rd_data_b_ff(rd_b),
    .wr_en(gpr_we),
    .wr_addr(dst_q),
    .wr_data(res)
  );

  assign signed_immediate_x = {{(XLEN-IMM_W){imm_q[IMM_W-1]}}, imm_q};
  assign unsigned_immediate_x = {{(XLEN-IMM_W){1'b0}}, imm_q};
  assign imm_hi = {imm_q, {(XLEN-IMM_W){1'b0}}};
  // register zero reads as zero only for OP_ADDI and OP_ADDIS
  assign ra_or0 = (src_a_q == '0) ? '0 : rd_a;

  always_comb begin
    add_x = rd_a;
    add_y = rd_b;
    add_cin = 1'b0;
    unique case (op_q)
      OP_ADDI: begin
        add_x = ra_or0;
        add_y = signed_immediate_x;
      end
      OP_ADDIS: begin
        add_x = ra_or0;
        add_y = imm_hi;
      end
      OP_ADDIC, OP_ADDIC_REC: add_y = signed_immediate_x;
      OP_SUBF, OP_SUBFC: begin
        add_x = ~rd_a;
        add_cin = 1'b1;
      end
      OP_SUBFIC: begin
        add_x = ~rd_a;
        add_y = signed_immediate_x;
        add_cin = 1'b1;
      end
      OP_ADDE: add_cin = xer_ff[XER_CA];
      OP_SUBFE: begin
        add_x = ~rd_a;
        add_cin = xer_ff[XER_CA];
      end
      OP_ADDME: begin
        add_y = ALL_ONES;
        add_cin = xer_ff[XER_CA];
      end
      OP_SUBFME: begin
        add_x = ~rd_a;
        add_y = ALL_ONES;
        add_cin = xer_ff[XER_CA];
      end
      OP_ADDZE: begin
        add_y = '0;
        add_cin = xer_ff[XER_CA];
      end
      OP_SUBFZE: begin
        add_x = ~rd_a;
        add_y = '0;
        add_cin = xer_ff[XER_CA];
      end
      OP_NEG: begin
        add_x = ~rd_a;
        add_y = '0;
        add_cin = 1'b1;
      end
      default: add_cin = 1'b0;
    endcase
  end

  assign sum = {1'b0, add_x} + {1'b0, add_y} + {{XLEN{1'b0}}, add_cin};
  assign sum_ov = (add_x[XLEN-1] == add_y[XLEN-1]) &&
                  (sum[XLEN-1] != add_x[XLEN-1]);

  assign mul_b = (op_q == OP_MULLI) ? signed_immediate_x : rd_b;
  assign prod_s = $signed({{XLEN{rd_a[XLEN-1]}}, rd_a}) *
                  $signed({{XLEN{mul_b[XLEN-1]}}, mul_b});
  assign prod_u = {{XLEN{1'b0}}, rd_a} * {{XLEN{1'b0}}, rd_b};
  assign mul_ov = prod_s[2*XLEN-1:XLEN] != {XLEN{prod_s[XLEN-1]}};

  // undefined quotients read as zero and raise overflow instead
  assign div_zero = (rd_b == '0);
  assign div_ovs = div_zero || ((rd_a == MIN_INT) && (rd_b == ALL_ONES));
  assign quot_s = div_ovs ? '0 : XLEN'($signed(rd_a) / $signed(rd_b));
  assign quot_u = div_zero ? '0 : rd_a / rd_b;

  assign cmp_b = (op_q == OP_CMPI) ? signed_immediate_x :
                 (op_q == OP_CMPLI) ? unsigned_immediate_x : rd_b;
  assign cmp_eq = (rd_a == cmp_b);
  assign cmp_lt = (op_q inside {OP_CMPI, OP_CMP}) ?
                  ($signed(rd_a) < $signed(cmp_b)) : (rd_a < cmp_b);
  assign cmp_nib = {cmp_lt, !cmp_lt && !cmp_eq, cmp_eq, xer_ff[XER_SO]};

  function automatic logic [XLEN-1:0] lead_zeros(input logic [XLEN-1:0] v);
    logic [XLEN-1:0] n;
    logic hit;
    n = '0;
    hit = 1'b0;
    for (int i = XLEN - 1; i >= 0; i--) begin
      hit = hit | v[i];
      n = n + {{(XLEN-1){1'b0}}, !hit};
    end
    return n;
  endfunction : lead_zeros

  always_comb begin
    res = sum[XLEN-1:0];
    ov = sum_ov;
    unique case (op_q)
      OP_MULLI, OP_MULLW: begin
        res = prod_s[XLEN-1:0];
        ov = mul_ov;
      end
      OP_MULHW: res = prod_s[2*XLEN-1:XLEN];
      OP_MULHWU: res = prod_u[2*XLEN-1:XLEN];
      OP_DIVW: begin
        res = quot_s;
        ov = div_ovs;
      end
      OP_DIVWU: begin
        res = quot_u;
        ov = div_zero;
      end
      OP_ANDI: res = rd_a & unsigned_immediate_x;
      OP_ANDIS: res = rd_a & imm_hi;
      OP_ORI: res = rd_a | unsigned_immediate_x;
      OP_ORIS: res = rd_a | imm_hi;
      OP_XORI: res = rd_a ^ unsigned_immediate_x;
      OP_XORIS: res = rd_a ^ imm_hi;
      OP_AND: res = rd_a & rd_b;
      OP_OR: res = rd_a | rd_b;
      OP_XOR: res = rd_a ^ rd_b;
      OP_NAND: res = ~(rd_a & rd_b);
      OP_NOR: res = ~(rd_a | rd_b);
      OP_EQV: res = ~(rd_a ^ rd_b);
      OP_ANDC: res = rd_a & ~rd_b;
      OP_ORC: res = rd_a | ~rd_b;
      OP_EXTSB: res = {{(XLEN-8){rd_a[7]}}, rd_a[7:0]};
      OP_EXTSH: res = {{(XLEN-16){rd_a[15]}}, rd_a[15:0]};
      OP_CNTLZW: res = lead_zeros(rd_a);
      default: ov = sum_ov;
    endcase
  end

  assign gpr_we = exec_go && !is_compare(op_q);
  assign ov_en = oe_q && has_oe(op_q);
  assign rec = always_rec(op_q) || (rc_q && has_rc(op_q));
  assign so_new = xer_ff[XER_SO] | (ov_en & ov);

  always_ff @(posedge clock) begin
    if (rst) begin
      result_ff <= '0;
      done_ff <= 1'b0;
      nop_drop_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      done_ff <= exec_go;
      nop_drop_ff <= take && is_nop;
      if (exec_go) begin
        result_ff <= res;
        cnt_ff <= cnt_ff + {{(XLEN-1){1'b0}}, 1'b1};
      end
    end
  end

  // the op's own update wins over a software write in the same edge
  // logical ops match neither enable below, so flags stay put
  always_ff @(posedge clock) begin
    if (rst) begin
      xer_ff <= XER_RST;
    end else if (exec_go) begin
      if (sets_ca(op_q)) begin
        xer_ff[XER_CA] <= sum[XLEN];
      end
      if (ov_en) begin
        xer_ff[XER_OV] <= ov;
        xer_ff[XER_SO] <= so_new;
      end
    end else if (sw_xer_wr) begin
      xer_ff <= pwdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cr_ff <= CR_RST;
    end else if (exec_go && is_compare(op_q)) begin
      cr_ff[field_lsb(crf_q) +: FIELD_W] <= cmp_nib;
    end else if (exec_go && rec) begin
      cr_ff[field_lsb(CRF_ZERO) +: FIELD_W] <= cr_char(res, so_new);
    end else if (sw_cr_wr) begin
      cr_ff <= pwdata;
    end
  end

  // apb slave: one wait state, writes land on the completing edge
  assign apb_done = psel && penable && pready_ff;
  assign sw_xer_wr = apb_done && pwrite && (paddr == OFS_XER);
  assign sw_cr_wr = apb_done && pwrite && (paddr == OFS_CR);

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (paddr)
      OFS_XER: rd_word = xer_ff;
      OFS_CR: rd_word = cr_ff;
      OFS_STAT: begin
        rd_word[STAT_BUSY] = (state_ff != ST_IDLE);
        rd_word[STAT_NOP] = nop_drop_ff;
      end
      OFS_CNT: rd_word = cnt_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !rd_hit;
      prdata_ff <= pwrite ? '0 : rd_word;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_take;
    take && !is_nop;
  endsequence
  sequence seq_run;
    ##1 (state_ff == ST_READ) ##1 exec_go ##1 done_ff;
  endsequence

  op_latency_a: assert property (seq_take |-> seq_run)
    else $error("op did not finish three cycles after take");
  hold_off_a: assert property (seq_take |=> !op_ready_ff [*2])
    else $error("next op accepted while busy");
  nop_drop_a: assert property (take && is_nop |=>
    nop_drop_ff && (state_ff == ST_IDLE) ##1 !done_ff)
    else $error("no-op not discarded");
  subf_order_a: assert property (done_ff && (op_q == OP_SUBF) |->
    result_ff == rd_b - rd_a)
    else $error("subtract-from operand order wrong");
  carry_out_a: assert property (done_ff && sets_ca(op_q) |->
    xer_ff[XER_CA] == $past(sum[XLEN]))
    else $error("carry flag not the msb carry out");
  ov_gate_a: assert property (done_ff && !ov_en |->
    $stable(xer_ff[XER_SO:XER_OV]))
    else $error("overflow flags touched without enable");
  sticky_so_a: assert property (exec_go && ov_en && ov |=>
    xer_ff[XER_SO] && xer_ff[XER_OV] ##1 xer_ff[XER_SO])
    else $error("overflow did not set both flags");
  logic_flags_a: assert property (done_ff && is_logic(op_q) |->
    $stable(xer_ff))
    else $error("logical op changed exception flags");
  cmp_field_a: assert property (done_ff && is_compare(op_q) |->
    cr_ff[field_lsb(crf_q) +: FIELD_W] == $past(cmp_nib))
    else $error("compare result in wrong field");
  record_cr0_a: assert property (done_ff && rec && !is_compare(op_q) |->
    cr_ff[field_lsb(CRF_ZERO) +: FIELD_W] ==
    cr_char(result_ff, xer_ff[XER_SO]))
    else $error("record form field zero wrong");
  plain_cr_a: assert property (done_ff && !rec && !is_compare(op_q) &&
    !$past(sw_cr_wr) |-> $stable(cr_ff))
    else $error("plain form changed condition reg");
  mulhwu_a: assert property (done_ff && (op_q == OP_MULHWU) |->
    result_ff == XLEN'(({{XLEN{1'b0}}, rd_a} * {{XLEN{1'b0}}, rd_b}) >>
    XLEN))
    else $error("unsigned high multiply wrong");
  apb_wait_a: assert property (psel && penable && !pready_ff |=>
    pready_ff ##1 !pready_ff)
    else $error("apb answer not after one wait state");
endmodule : ial_top
`default_nettype wire

// ===== test/ial_disp_model.sv
`timescale 1ns/100ps
`default_nettype none
module ial_disp_model (
  input wire logic clock,
  input wire logic op_ready_ff,
  output var logic op_valid,
  output var ial_pkg::ial_op_t op_code,
  output var logic [ial_pkg::REG_AW-1:0] op_dst,
  output var logic [ial_pkg::REG_AW-1:0] op_src_a,
  output var logic [ial_pkg::REG_AW-1:0] op_src_b,
  output var logic [ial_pkg::IMM_W-1:0] op_imm,
  output var logic op_oe,
  output var logic op_rc,
  output var logic [ial_pkg::CRF_W-1:0] op_crf,
  output var logic op_trace_pend
);
  import ial_pkg::*;

  initial begin
    op_valid = 1'b0;
    op_code = OP_ADDI;
    {op_dst, op_src_a, op_src_b, op_imm, op_oe, op_rc, op_crf,
      op_trace_pend} = '0;
  end

  // the offer stands until ready is seen at an edge; after the take the
  // fields carry inverted junk so a late sample cannot match by luck
  task automatic issue(input ial_op_t c, input logic [4:0] d, a, b,
                       input logic [15:0] i, input logic oe, rc,
                       input logic [2:0] f, input logic tp);
    op_valid <= 1'b1;
    op_code <= c;
    {op_dst, op_src_a, op_src_b, op_imm, op_oe, op_rc, op_crf,
      op_trace_pend} <= {d, a, b, i, oe, rc, f, tp};
    do @(posedge clock); while (op_ready_ff !== 1'b1);
    op_valid <= 1'b0;
    op_code <= ial_op_t'(~c);
    {op_dst, op_src_a, op_src_b, op_imm, op_oe, op_rc, op_crf,
      op_trace_pend} <= ~{d, a, b, i, oe, rc, f, tp};
  endtask : issue
endmodule : ial_disp_model
`default_nettype wire

// ===== test/ial_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); \
  end \
end
module ial_top_bench;
  import ial_pkg::*;
  localparam int LIMIT = 20000;
  logic clock, rst, op_valid, op_oe, op_rc, op_trace_pend;
  ial_op_t op_code;
  logic [REG_AW-1:0] op_dst, op_src_a, op_src_b;
  logic [IMM_W-1:0] op_imm;
  logic [CRF_W-1:0] op_crf;
  logic op_ready_ff, done_ff, nop_drop_ff, pready_ff, pslverr_ff;
  logic [XLEN-1:0] result_ff, xer_ff, cr_ff, prdata_ff, pwdata;
  logic psel, penable, pwrite, er, sn, dn;
  logic [ADDR_W-1:0] paddr;
  logic [XLEN-1:0] gpr [REG_N];
  logic [XLEN-1:0] xs, crs, rd, w;
  int fails, n_compared, cyc, ne;

  ial_top i_dut (.clock, .rst, .op_valid, .op_code, .op_dst, .op_src_a,
    .op_src_b, .op_imm, .op_oe, .op_rc, .op_crf, .op_trace_pend,
    .op_ready_ff, .done_ff, .nop_drop_ff, .result_ff, .xer_ff, .cr_ff,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff);
  ial_disp_model i_disp (.clock, .op_ready_ff, .op_valid, .op_code,
    .op_dst, .op_src_a, .op_src_b, .op_imm, .op_oe, .op_rc, .op_crf,
    .op_trace_pend);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // reference: x and cr are the flag shadows, updated in place
  function automatic void predict(input ial_op_t c, input logic [31:0] a,
      b, input logic [15:0] i, input logic oe, rc, input logic [2:0] f,
      inout logic [31:0] x, cr, output logic [31:0] r);
    logic [31:0] si, p, q;
    logic [32:0] s;
    logic [63:0] m;
    logic k, v, lt;
    si = {{16{i[15]}}, i};
    p = a;
    q = b;
    k = 1'b0;
    case (c)
      OP_ADDI, OP_ADDIC, OP_ADDIC_REC: q = si;
      OP_ADDIS: q = {i, 16'h0};
      OP_SUBF, OP_SUBFC: {p, k} = {~a, 1'b1};
      OP_SUBFIC: {p, q, k} = {~a, si, 1'b1};
      OP_ADDE: k = x[XER_CA];
      OP_SUBFE: {p, k} = {~a, x[XER_CA]};
      OP_ADDME: {q, k} = {ALL_ONES, x[XER_CA]};
      OP_SUBFME: {p, q, k} = {~a, ALL_ONES, x[XER_CA]};
      OP_ADDZE: {q, k} = {32'h0, x[XER_CA]};
      OP_SUBFZE: {p, q, k} = {~a, 32'h0, x[XER_CA]};
      OP_NEG: {p, q, k} = {~a, 32'h0, 1'b1};
      default: ;
    endcase
    s = {1'b0, p} + {1'b0, q} + 33'(k);
    r = s[31:0];
    v = (p[31] == q[31]) && (s[31] != p[31]);
    m = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    case (c)
      OP_MULLI: r = a * si;
      OP_MULLW: {v, r} = {m[63:32] != {32{m[31]}}, m[31:0]};
      OP_MULHW: r = m[63:32];
      OP_MULHWU: r = 32'(({32'h0, a} * {32'h0, b}) >> 32);
      OP_DIVW: {v, r} = (b == 0 || (a == MIN_INT && b == ALL_ONES)) ?
          {1'b1, 32'h0} : {1'b0, 32'($signed(a) / $signed(b))};
      OP_DIVWU: {v, r} = (b == 0) ? {1'b1, 32'h0} : {1'b0, a / b};
      OP_ANDI: r = a & {16'h0, i};
      OP_ANDIS: r = a & {i, 16'h0};
      OP_ORI: r = a | {16'h0, i};
      OP_ORIS: r = a | {i, 16'h0};
      OP_XORI: r = a ^ {16'h0, i};
      OP_XORIS: r = a ^ {i, 16'h0};
      OP_AND: r = a & b;
      OP_OR: r = a | b;
      OP_XOR: r = a ^ b;
      OP_NAND: r = ~(a & b);
      OP_NOR: r = ~(a | b);
      OP_EQV: r = ~(a ^ b);
      OP_ANDC: r = a & ~b;
      OP_ORC: r = a | ~b;
      OP_EXTSB: r = {{24{a[7]}}, a[7:0]};
      OP_EXTSH: r = {{16{a[15]}}, a[15:0]};
      OP_CNTLZW: begin
        r = 32'h0;
        while (r < 32 && !a[31 - r]) r++;
      end
      default: ;
    endcase
    if (c inside {OP_CMPI, OP_CMP, OP_CMPLI, OP_CMPL}) begin
      q = (c == OP_CMPI) ? si : (c == OP_CMPLI) ? {16'h0, i} : b;
      lt = (c inside {OP_CMPI, OP_CMP}) ? $signed(a) < $signed(q) : a < q;
      cr[31 - 4 * int'(f) -: 4] = {lt, !lt && a != q, a == q, x[XER_SO]};
      return;
    end
    if (c inside {[OP_ADDIC:OP_SUBFZE]}) x[XER_CA] = s[32];
    if (oe && c inside {OP_ADD, OP_SUBF, [OP_ADDC:OP_NEG], OP_MULLW,
        OP_DIVW, OP_DIVWU}) x[XER_SO:XER_OV] = {x[XER_SO] | v, v};
    if (c inside {OP_ADDIC_REC, OP_ANDI, OP_ANDIS} || (rc && !(c inside
        {OP_ADDI, OP_ADDIS, OP_ADDIC, OP_SUBFIC, OP_MULLI,
         [OP_CMPI:OP_XORIS]})))
      cr[31:28] = {r[31], !r[31] && r != 0, r == 0, x[XER_SO]};
  endfunction : predict

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready_ff !== 1'b1 && k < 20);
    // a bus that never answers counts as a mismatch
    if (pready_ff !== 1'b1) fails++;
    r = prdata_ff;
    e = pslverr_ff;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic op(input ial_op_t c, input logic [4:0] d, a, b,
                    input logic [15:0] i, input logic oe, rc,
                    input logic [2:0] f);
    logic [31:0] r;
    int k;
    predict(c, (a == 0 && c inside {OP_ADDI, OP_ADDIS}) ? 32'h0 : gpr[a],
            gpr[b], i, oe, rc, f, xs, crs, r);
    i_disp.issue(c, d, a, b, i, oe, rc, f, 1'b0);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (done_ff !== 1'b1 && k < 12);
    ne++;
    `CHK("done", 1'b1, done_ff)
    if (!(c inside {OP_CMPI, OP_CMP, OP_CMPLI, OP_CMPL})) begin
      gpr[d] = r;
      `CHK("result", r, result_ff)
    end
    `CHK("xer", xs, xer_ff)
    `CHK("cr", crs, cr_ff)
  endtask : op

  initial begin
    void'($urandom(32'h5cbed5fb));
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    xs = XER_RST;
    crs = CR_RST;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    // general regs have no reset, so every one is loaded first
    for (int n = 0; n < 32; n++) begin
      w = $urandom();
      op(OP_ADDIS, 5'(n), 5'h0, 5'h0, w[31:16], 1'b0, 1'b0, 3'h0);
      op(OP_ORI, 5'(n), 5'(n), 5'h0, w[15:0] | 16'h1, 1'b0, 1'b0, 3'h0);
    end
    op(OP_ADDIS, 5'd1, 5'h0, 5'h0, 16'h8000, 1'b0, 1'b0, 3'h0);
    op(OP_ADDI, 5'd2, 5'h0, 5'h0, 16'hffff, 1'b0, 1'b0, 3'h0);
    op(OP_ADDI, 5'd3, 5'h0, 5'h0, 16'h0, 1'b0, 1'b0, 3'h0);
    op(OP_ADDIS, 5'd4, 5'h0, 5'h0, 16'h8000, 1'b0, 1'b0, 3'h0);
    op(OP_ADDI, 5'd4, 5'd4, 5'h0, 16'hffff, 1'b0, 1'b0, 3'h0);
    op(OP_CMP, 5'h0, 5'd1, 5'd4, 16'h0, 1'b0, 1'b0, 3'h7);
    op(OP_CMPL, 5'h0, 5'd1, 5'd4, 16'h0, 1'b0, 1'b0, 3'h0);
    op(OP_SUBF, 5'd5, 5'd3, 5'd4, 16'h0, 1'b0, 1'b1, 3'h0);
    op(OP_ADD, 5'd5, 5'd4, 5'd4, 16'h0, 1'b0, 1'b0, 3'h0);
    op(OP_ADD, 5'd5, 5'd4, 5'd4, 16'h0, 1'b1, 1'b1, 3'h0);
    op(OP_NEG, 5'd5, 5'd1, 5'h0, 16'h0, 1'b1, 1'b1, 3'h0);
    op(OP_DIVW, 5'd5, 5'd1, 5'd2, 16'h0, 1'b1, 1'b1, 3'h0);
    op(OP_DIVWU, 5'd5, 5'd4, 5'd3, 16'h0, 1'b1, 1'b0, 3'h0);
    w = $urandom();
    apb(1'b1, OFS_CR, w, rd, er);
    crs = w;
    apb(1'b0, OFS_CR, 32'h0, rd, er);
    `CHK("cr read", crs, rd)
    apb(1'b1, 12'h010, w, rd, er);
    `CHK("unmapped", 1'b1, er)
    for (int rep = 0; rep < 4; rep++) begin
      w = $urandom();
      xs = {w[2:0], 29'h0};
      apb(1'b1, OFS_XER, xs, rd, er);
      apb(1'b0, OFS_XER, 32'h0, rd, er);
      `CHK("xer read", xs, rd)
      for (int n = 0; n <= 42; n++) begin
        w = $urandom();
        op(ial_op_t'(n), w[4:0], 5'($urandom_range(31, 1)), w[9:5],
           w[25:10], w[26], w[27], w[30:28]);
      end
    end
    // preferred no-op: dropped unless a trace is pending
    for (int t = 0; t < 2; t++) begin
      i_disp.issue(OP_ORI, 5'h0, 5'h0, 5'h0, 16'h0, 1'b0, 1'b0, 3'h0,
                   t[0]);
      sn = 1'b0;
      dn = 1'b0;
      repeat (6) begin
        @(posedge clock);
        sn |= nop_drop_ff;
        dn |= done_ff;
      end
      `CHK("dropped", !t[0], sn)
      `CHK("executed", t[0], dn)
      `CHK("xer kept", xs, xer_ff)
      `CHK("cr kept", crs, cr_ff)
      ne += t;
    end
    `CHK("traced ori", gpr[0], result_ff)
    // discarded no-ops must not reach the executed-op counter
    apb(1'b0, OFS_CNT, 32'h0, rd, er);
    `CHK("op count", 32'(ne), rd)
    results();
  end
endmodule : ial_top_bench
`undef CHK
`default_nettype wire
